// *** subiu_pkg.sv ***
// Purpose: Shared constants and types for the subtract instruction unit.
// Assumes: 14-bit instruction words, 8-bit data path, 7-bit file address.
// Notes:   Phase enumeration is shared by the phase sequencer and the datapath.
package subiu_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned INSN_W = 14;
    // Immediate subtract: 11 110x kkkk kkkk.
    localparam logic [4:0]  IMM_OP_VAL   = 5'h1e;
    localparam int unsigned IMM_OP_MSB   = 13;
    localparam int unsigned IMM_OP_LSB   = 9;
    // Register subtract: 00 0010 dfff ffff.
    localparam logic [5:0]  REG_OP_VAL   = 6'h02;
    localparam int unsigned REG_OP_MSB   = 13;
    localparam int unsigned REG_OP_LSB   = 8;
    localparam int unsigned DEST_BIT     = 7;
    localparam int unsigned IMM_MSB      = 7;
    localparam int unsigned ADDR_MSB     = 6;
    localparam logic [7:0]  ACC_RESET    = 8'h00;
    localparam logic [1:0]  PHASE_RESET  = 2'h0;
    typedef enum logic [1:0] {
        SUBIU_Q1,
        SUBIU_Q2,
        SUBIU_Q3,
        SUBIU_Q4
    } subiu_phase_t;
endpackage

// *** subiu_phase.sv ***
// Purpose: Four-phase sequencer that splits each instruction cycle into Q1..Q4.
// Assumes: One phase per clock; the cycle restarts at Q1 after reset.
// Notes:   The phase is a registered output so all consumers see the same edge.
`timescale 1ns/1ps
`default_nettype none
module subiu_phase (
    input  wire logic                   i_clk,
    input  wire logic                   i_resetn,
    output subiu_pkg::subiu_phase_t     o_phase
);
    typedef struct packed {
        logic [1:0] ph;
    } subiu_phase_state_t;

    subiu_phase_state_t s_q;
    subiu_phase_state_t s_d;

    always_comb begin
        s_d    = s_q;
        s_d.ph = s_q.ph + 2'h1;
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            s_q.ph <= subiu_pkg::PHASE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_phase = subiu_pkg::subiu_phase_t'(s_q.ph);
endmodule // subiu_phase
`default_nettype wire

// *** subiu_top.sv ***
// Purpose: Datapath for the immediate and register subtract instructions.
// Assumes: Decoder holds i_insn for a whole cycle; register data is valid from Q2.
// Notes:   Other opcodes pass through untouched; status writes go to o_stat_*.
//
// What this block does
// - Immediate subtract decodes Q1, fetches immediate Q2, computes Q3, writes Q4.
// - Immediate subtract puts immediate minus accumulator, 8 bits, into accumulator.
// - Positive difference sets borrow bit and clears the zero flag.
// - Zero difference sets both the borrow bit and the zero flag.
// - Negative difference clears borrow and zero; result wraps modulo 256.
// - Register subtract computes register minus accumulator; dest bit picks target.
// - Register subtract takes a 7-bit bank address and one destination bit.
// - Immediate subtract opcode is 11 110x followed by the 8-bit immediate.
// - Only borrow, nibble-borrow and zero status bits are updated.
`timescale 1ns/1ps
`default_nettype none
module subiu_top (
    input  wire logic                   i_clk,
    input  wire logic                   i_resetn,
    input  wire logic [13:0]            i_insn,
    input  wire logic [7:0]             i_reg_rdata,
    output logic      [6:0]             o_reg_addr,
    output logic                        o_reg_we,
    output logic      [7:0]             o_reg_wdata,
    output logic      [7:0]             o_acc,
    output logic                        o_stat_we,
    output logic                        o_carry,
    output logic                        o_nibble_borrow_bit,
    output logic                        o_zero,
    output subiu_pkg::subiu_phase_t     o_phase
);
    typedef struct packed {
        logic       is_imm;
        logic       is_reg;
        logic       dest;
        logic [6:0] addr;
        logic [7:0] minuend;
        logic [7:0] diff;
        logic       carry_n;
        logic       nib;
        logic       zero_n;
        logic [7:0] acc;
        logic       reg_we;
        logic [7:0] reg_wdata;
        logic       stat_we;
        logic       carry;
        logic       nibble;
        logic       zero;
    } subiu_state_t;

    subiu_state_t            s_q;
    subiu_state_t            s_d;
    subiu_pkg::subiu_phase_t phase;

    subiu_phase u_phase (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .o_phase  (phase)
    );

    function automatic logic dec_imm(input logic [13:0] w);
        dec_imm = (w[subiu_pkg::IMM_OP_MSB:subiu_pkg::IMM_OP_LSB]
                   == subiu_pkg::IMM_OP_VAL);
    endfunction

    function automatic logic dec_reg(input logic [13:0] w);
        dec_reg = (w[subiu_pkg::REG_OP_MSB:subiu_pkg::REG_OP_LSB] == subiu_pkg::REG_OP_VAL);
    endfunction

    logic [8:0] full_sum;
    logic [4:0] low_sum;

    always_comb begin
        s_d         = s_q;
        s_d.reg_we  = 1'b0;
        s_d.stat_we = 1'b0;
        // Subtraction as a + ~b + 1 so the carry out is the no-borrow flag directly.
        full_sum = {1'b0, s_q.minuend} + {1'b0, ~s_q.acc} + 9'h001;
        low_sum  = {1'b0, s_q.minuend[3:0]} + {1'b0, ~s_q.acc[3:0]} + 5'h01;
        unique case (phase)
            subiu_pkg::SUBIU_Q1: begin
                s_d.is_imm = dec_imm(i_insn);
                s_d.is_reg = dec_reg(i_insn);
                s_d.dest   = i_insn[subiu_pkg::DEST_BIT];
                s_d.addr   = i_insn[subiu_pkg::ADDR_MSB:0];
            end
            subiu_pkg::SUBIU_Q2: begin
                if (s_q.is_imm) begin
                    s_d.minuend = i_insn[subiu_pkg::IMM_MSB:0];
                end else begin
                    s_d.minuend = i_reg_rdata;
                end
            end
            subiu_pkg::SUBIU_Q3: begin
                s_d.diff    = full_sum[7:0];
                s_d.carry_n = full_sum[8];
                s_d.nib     = low_sum[4];
                s_d.zero_n  = (full_sum[7:0] == 8'h00);
            end
            subiu_pkg::SUBIU_Q4: begin
                if (s_q.is_imm || s_q.is_reg) begin
                    s_d.stat_we = 1'b1;
                    s_d.carry   = s_q.carry_n;
                    s_d.nibble  = s_q.nib;
                    s_d.zero    = s_q.zero_n;
                    if (s_q.is_reg && s_q.dest) begin
                        s_d.reg_we    = 1'b1;
                        s_d.reg_wdata = s_q.diff;
                    end else begin
                        s_d.acc = s_q.diff;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            s_q     <= '0;
            s_q.acc <= subiu_pkg::ACC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_reg_addr          = s_q.addr;
    assign o_reg_we            = s_q.reg_we;
    assign o_reg_wdata         = s_q.reg_wdata;
    assign o_acc               = s_q.acc;
    assign o_stat_we           = s_q.stat_we;
    assign o_carry             = s_q.carry;
    assign o_nibble_borrow_bit = s_q.nibble;
    assign o_zero              = s_q.zero;
    assign o_phase             = phase;

    // The checkers match opcodes from the encodings so a broken decode function is caught.
    logic op_imm_seen;
    logic op_reg_seen;
    assign op_imm_seen = i_insn[subiu_pkg::IMM_OP_MSB:subiu_pkg::IMM_OP_LSB]
                         == subiu_pkg::IMM_OP_VAL;
    assign op_reg_seen = i_insn[subiu_pkg::REG_OP_MSB:subiu_pkg::REG_OP_LSB]
                         == subiu_pkg::REG_OP_VAL;

    // Writes only become visible on the edge that ends Q4.
    write_phase_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (o_stat_we || o_reg_we) |-> $past(phase) == subiu_pkg::SUBIU_Q4)
        else $error("write outside Q4");
    pulse_once_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (o_stat_we || o_reg_we) |=> (!o_stat_we && !o_reg_we))
        else $error("write pulse longer than one cycle");
    phase_order_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase == subiu_pkg::SUBIU_Q4) |=> (phase == subiu_pkg::SUBIU_Q1))
        else $error("cycle did not restart at Q1");
    // Reset must leave the unit at Q1 with nothing pending, or a stale write follows release.
    reset_state_a: assert property (@(posedge i_clk)
        !i_resetn |=> (phase == subiu_pkg::SUBIU_Q1 && !o_stat_we && !o_reg_we
                       && o_acc == subiu_pkg::ACC_RESET))
        else $error("reset left the unit busy");
    zero_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (o_stat_we && !o_reg_we) |-> (o_zero == (o_acc == 8'h00)))
        else $error("zero flag does not match result");
    zero_reg_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (o_stat_we && o_reg_we) |-> (o_zero == (o_reg_wdata == 8'h00)))
        else $error("zero flag does not match register result");
    zero_carry_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (o_stat_we && o_zero) |-> o_carry)
        else $error("zero result without carry");
    zero_nibble_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (o_stat_we && o_zero) |-> o_nibble_borrow_bit)
        else $error("zero result with nibble borrow");
    imm_result_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase == subiu_pkg::SUBIU_Q1 && op_imm_seen)
        |-> ##4 (o_stat_we && !o_reg_we))
        else $error("immediate subtract not carried out");
    // The decoder may move on after Q4, so the immediate is taken as it stood at Q2.
    imm_value_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase == subiu_pkg::SUBIU_Q2 && s_q.is_imm && $stable(i_insn))
        |-> ##3 o_stat_we && (o_acc == 8'($past(i_insn[7:0], 3) - $past(o_acc, 3))))
        else $error("immediate result wrong");
    // Register data is checked as it stood at the end of Q2, when the unit took it.
    reg_result_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase == subiu_pkg::SUBIU_Q1 && op_reg_seen && i_insn[subiu_pkg::DEST_BIT])
        |-> ##4 o_reg_we && o_stat_we
        && (o_reg_wdata == 8'($past(i_reg_rdata, 3) - $past(o_acc, 4))))
        else $error("register result wrong");
    reg_to_acc_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase == subiu_pkg::SUBIU_Q1 && op_reg_seen && !i_insn[subiu_pkg::DEST_BIT])
        |-> ##4 o_stat_we && !o_reg_we
        && (o_acc == 8'($past(i_reg_rdata, 3) - $past(o_acc, 4))))
        else $error("register result to accumulator wrong");
    reg_addr_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase == subiu_pkg::SUBIU_Q1) |=> (o_reg_addr == $past(i_insn[subiu_pkg::ADDR_MSB:0])))
        else $error("register address not taken in Q1");
    borrow_bit_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase == subiu_pkg::SUBIU_Q4 && (s_q.is_imm || s_q.is_reg))
        |=> o_carry == ($past(s_q.minuend) >= $past(s_q.acc)))
        else $error("borrow bit wrong");
    nibble_borrow_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase == subiu_pkg::SUBIU_Q4 && (s_q.is_imm || s_q.is_reg))
        |=> o_nibble_borrow_bit == ($past(s_q.minuend[3:0]) >= $past(s_q.acc[3:0])))
        else $error("nibble borrow wrong");
    dest_reg_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_reg_we |-> $stable(o_acc) && o_stat_we)
        else $error("register target also touched accumulator");
    status_only_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !o_stat_we |-> $stable(o_carry) && $stable(o_zero)
        && $stable(o_nibble_borrow_bit))
        else $error("status changed without an update");
    other_op_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase == subiu_pkg::SUBIU_Q1 && !op_imm_seen && !op_reg_seen)
        |-> ##4 (!o_stat_we && !o_reg_we && $stable(o_acc)))
        else $error("unrelated opcode changed the unit");
    acc_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !o_stat_we |-> $stable(o_acc))
        else $error("accumulator changed without an update");

    imm_cover_c: cover property (@(posedge i_clk) o_stat_we && !o_reg_we);
    reg_cover_c: cover property (@(posedge i_clk) o_reg_we);
    neg_cover_c: cover property (@(posedge i_clk) o_stat_we && !o_carry);
    zero_cover_c: cover property (@(posedge i_clk) o_stat_we && o_zero);
    nib_cover_c: cover property (@(posedge i_clk) o_stat_we && !o_nibble_borrow_bit);
endmodule // subiu_top
`default_nettype wire

// *** subiu_core_model.sv ***
// Purpose: Register file model standing where the decoder side meets the unit.
// Assumes: Data is read during Q2 and written on the write pulse.
// Notes:   Outside Q2 the read bus shows the inverse of its last value.
`timescale 1ns/1ps
`default_nettype none
module subiu_core_model (
    input  wire logic                   i_clk,
    input  wire logic                   i_phase_q2,
    input  wire logic [6:0]             i_addr,
    input  wire logic                   i_we,
    input  wire logic [7:0]             i_wdata,
    output logic      [7:0]             o_rdata
);
    logic [7:0] mem [128];
    logic [7:0] last_q;
    initial begin
        last_q = 8'h5a;
        for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 11);
    end
    always @(posedge i_clk) begin
        if (i_we) mem[i_addr] <= i_wdata;
        last_q <= o_rdata;
    end
    // A stale bus must never look valid, so it toggles every idle cycle.
    assign o_rdata = i_phase_q2 ? mem[i_addr] : ~last_q;
endmodule // subiu_core_model
`default_nettype wire

// *** subtract_instruction_unit_tb.sv ***
// Purpose: Self-checking bench for the subtract unit against an integer model.
// Assumes: One instruction per four-phase cycle, inputs driven on falling edges.
// Notes:   Each result is checked on the falling edge after the Q4 edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module subtract_instruction_unit_tb;
    logic                    i_clk = 1'b0;
    logic                    i_resetn = 1'b0;
    logic [13:0]             i_insn = 14'h0000;
    logic [7:0]              rdata, wdata, acc;
    logic [6:0]              addr;
    logic                    reg_we, stat_we, carry, nbb, zero;
    subiu_pkg::subiu_phase_t phase;
    int err_total = 0, n_compared = 0, seed = 32'hee99;
    int m_acc = 0, m, dif, e_c = 0, e_z = 0, e_n = 0;
    int mem [128];
    always #20 i_clk = ~i_clk;
    subiu_top dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_insn(i_insn),
        .i_reg_rdata(rdata), .o_reg_addr(addr), .o_reg_we(reg_we), .o_reg_wdata(wdata),
        .o_acc(acc), .o_stat_we(stat_we), .o_carry(carry), .o_nibble_borrow_bit(nbb),
        .o_zero(zero), .o_phase(phase));
    subiu_core_model core_u (.i_clk(i_clk), .i_phase_q2(phase == subiu_pkg::SUBIU_Q2),
        .i_addr(addr), .i_we(reg_we), .i_wdata(wdata), .o_rdata(rdata));
    task automatic give_verdict();
        $display("compared=%0d errors=%0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Kind 0 is an immediate subtract, 1 a register subtract, 2 an unrelated opcode.
    task automatic run(input int kind, input logic [7:0] k, input logic d,
                       input logic [6:0] a);
        logic [13:0] w;
        w = kind == 0 ? {subiu_pkg::IMM_OP_VAL, d, k} :
            kind == 1 ? {subiu_pkg::REG_OP_VAL, d, a} : {6'h39, k};
        i_insn = w;
        m = kind == 0 ? int'(k) : mem[a];
        dif = (m - m_acc) & 255;
        repeat (4) @(negedge i_clk);
        `CHK(phase, subiu_pkg::SUBIU_Q1)
        `CHK(stat_we, 1'(kind < 2))
        if (kind == 1) `CHK(addr, a)
        `CHK(reg_we, 1'(kind == 1 && d))
        if (kind < 2) begin
            e_c = m >= m_acc;
            e_z = dif == 0;
            e_n = (m & 15) >= (m_acc & 15);
            if (kind == 1 && d) begin
                `CHK(wdata, 8'(dif))
                mem[a] = dif;
            end else begin
                m_acc = dif;
            end
        end
        `CHK(carry, 1'(e_c))
        `CHK(zero, 1'(e_z))
        `CHK(nbb, 1'(e_n))
        `CHK(acc, 8'(m_acc))
    endtask
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = (i * 37 + 11) & 255;
        repeat (3) @(negedge i_clk);
        i_resetn = 1'b1;
        run(0, 8'h01, 1'b0, 7'h00);
        run(0, 8'h02, 1'b1, 7'h00);
        run(0, 8'h01, 1'b0, 7'h00);
        run(0, 8'h03, 1'b1, 7'h00);
        run(0, 8'h02, 1'b0, 7'h00);
        repeat (60) run({$random(seed)} % 3, 8'($random(seed)), 1'($random(seed)),
                        7'($random(seed)));
        give_verdict();
    end
endmodule // subtract_instruction_unit_tb
`default_nettype wire
